// ### hdl/mfs_pkg.sv
// register map, field layout and timing constants of the frame-sync block
// assumes a 16-bit i/o register space reached by word strobes
package mfs_pkg;
	localparam logic [15:0] ADDR_STATUS_CONFIG = 16'hfff2;
	localparam logic [15:0] ADDR_CHANNEL_CONFIG = 16'hfff3;
	localparam logic [15:0] ADDR_PRESCALER = 16'hfffb;

	localparam logic [15:0] RST_STATUS_CONFIG = 16'h0000;
	localparam logic [15:0] RST_CHANNEL_CONFIG = 16'h0000;
	localparam logic [7:0] RST_SHIFT_CLOCK_DIV = 8'h00;
	localparam logic [7:0] RST_FRAME_SYNC_DIV = 8'h00;

	// status/config bit positions
	localparam int SC_DATA_IN_BIT = 15;
	localparam int SC_FS_INVERT_BIT = 14;
	localparam int SC_FS_SOURCE_BIT = 13;
	localparam int SC_FS_ZERO_BIT = 12;
	localparam int SC_CLK_INVERT_BIT = 10;
	localparam int SC_CLK_SOURCE_BIT = 9;
	localparam int SC_PRESCALE_EN_BIT = 8;
	localparam int SC_BYTE_MODE_BIT = 0;
	localparam int SC_SIGN_EXT_BIT = 1;

	// channel_config bit positions
	localparam int CC_COUNT_LSB = 0;
	localparam int CC_ENHANCED_BIT = 2;

	// prescaler register byte lanes
	localparam int PR_SHIFT_LSB = 0;
	localparam int PR_FRAME_LSB = 8;

	// shift-clock periods between consecutive channel frame syncs
	localparam int FS_SPACING = 18;
	localparam logic [4:0] FS_SPACING_LAST = 5'(FS_SPACING - 1);
	localparam int WORD_BITS = 16;
	localparam int BYTE_BITS = 8;

	typedef struct packed {
		logic       fs_invert;
		logic       fs_source;
		logic       clk_invert;
		logic       clk_source;
		logic       prescale_en;
		logic       sign_ext;
		logic       byte_mode;
	} mfs_cfg_s;

	typedef enum logic [0:0] {
		TX_IDLE  = 1'b0,
		TX_SHIFT = 1'b1
	} mfs_tx_e;
endpackage

// ### hdl/mfs_frame_sync.sv
// transmit frame-sync generation, data pin and multichannel frame-sync fan-out
// assumes i/o strobes and tx word handshake synchronous to clock
`timescale 1ns/1ps
module mfs_frame_sync
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [15:0] io_addr,
	input  wire logic [15:0] io_wdata,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	output logic      [15:0] io_rdata,
	input  wire logic        transmit_mode_bit,
	input  wire logic [15:0] tx_word,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	input  wire logic        serial_data_in,
	output logic             shift_clock_pin_o,
	input  wire logic        transmit_frame_sync_i,
	output logic             transmit_frame_sync_o,
	output logic             transmit_frame_sync_oe,
	output logic             receive_clock_pin_o,
	output logic             receive_clock_pin_oe,
	output logic             receive_frame_sync_o,
	output logic             receive_frame_sync_oe,
	input  wire logic        general_purpose_pin_i,
	output logic             general_purpose_pin_o,
	output logic             general_purpose_pin_oe,
	input  wire logic        gp_out_value,
	input  wire logic        gp_drive,
	output logic             gp_in_value,
	output logic             serial_data_out_o,
	output logic             serial_data_out_oe,
	output logic             transmit_busy
);
	mfs_pkg::mfs_cfg_s cfg_ff;
	logic              fs_zero_flag_ff;
	logic [15:0]       chan_cfg_ff;
	logic [7:0]        shift_clock_prescaler_ff;
	logic [7:0]        frame_sync_prescaler_ff;
	logic [15:0]       rdata_ff;

	logic [7:0]        div_cnt_ff;
	logic              sck_ff;
	logic [8:0]        fs_cnt_ff;
	logic              seq_act_ff;
	logic [1:0]        seq_ch_ff;
	logic [4:0]        gap_ff;
	logic [3:0]        pulse_ff;
	logic              ext_fs_ff;
	mfs_pkg::mfs_tx_e  tx_state_ff;
	logic [15:0]       shifter_ff;
	logic [3:0]        bit_cnt_ff;
	logic [3:0]        load_cnt_q;

	// address decode
	wire sel_sc = io_addr == mfs_pkg::ADDR_STATUS_CONFIG;
	wire sel_cc = io_addr == mfs_pkg::ADDR_CHANNEL_CONFIG;
	wire sel_pr = io_addr == mfs_pkg::ADDR_PRESCALER;
	wire wr_sc  = io_wr && sel_sc;
	wire wr_cc  = io_wr && sel_cc;
	wire wr_pr  = io_wr && sel_pr;

	wire [15:0] sc_read = {serial_data_in, cfg_ff.fs_invert,
		cfg_ff.fs_source, fs_zero_flag_ff, 1'b0, cfg_ff.clk_invert,
		cfg_ff.clk_source, cfg_ff.prescale_en, 6'h00,
		cfg_ff.sign_ext, cfg_ff.byte_mode};
	wire [15:0] pr_read = {frame_sync_prescaler_ff,
		shift_clock_prescaler_ff};
	wire [15:0] nxt_rdata = sel_sc ? sc_read
		: sel_cc ? chan_cfg_ff
		: sel_pr ? pr_read
		: 16'h0000;

	// mode decode
	wire       enhanced = chan_cfg_ff[mfs_pkg::CC_ENHANCED_BIT];
	wire [1:0] ch_last  = enhanced
		? chan_cfg_ff[mfs_pkg::CC_COUNT_LSB +: 2] : 2'd0;
	wire       drive_fs = transmit_mode_bit;

	// shift clock: period 2*(prescaler+1) system clocks
	wire div_wrap = cfg_ff.prescale_en
		&& div_cnt_ff == shift_clock_prescaler_ff;
	wire rise     = div_wrap && !sck_ff;

	// frame prescaler counts shift periods, reload 2*(n+1)-1
	wire [8:0] fs_reload = {frame_sync_prescaler_ff, 1'b1};
	wire       fs_zero   = rise && fs_cnt_ff == 9'h000;
	wire       pulse_end = rise && |pulse_ff;

	// external sync seen on shift-clock ticks, polarity folded in
	wire ext_lvl  = transmit_frame_sync_i ^ cfg_ff.fs_invert;
	wire ext_fall = rise && !drive_fs && ext_fs_ff && !ext_lvl;

	wire tx_idle   = tx_state_ff == mfs_pkg::TX_IDLE;
	// internal pacing: prescaler zero, or a word waiting while quiet
	wire trig_pre  = fs_zero && cfg_ff.fs_source;
	wire trig_fifo = rise && !cfg_ff.fs_source && tx_valid
		&& tx_idle && !(|pulse_ff);
	wire trigger   = drive_fs && !seq_act_ff
		&& (trig_pre || trig_fifo);
	wire gap_done  = rise && seq_act_ff && gap_ff == mfs_pkg::FS_SPACING_LAST;
	wire more_ch   = seq_ch_ff < ch_last;

	// a word goes out at the falling edge of any channel sync
	wire start    = pulse_end || ext_fall;
	assign tx_ready = start && tx_valid;
	wire [15:0] load_word = cfg_ff.byte_mode
		? {tx_word[7:0], 8'h00} : tx_word;
	wire [3:0]  load_cnt = cfg_ff.byte_mode
		? 4'(mfs_pkg::BYTE_BITS - 1) : 4'(mfs_pkg::WORD_BITS - 1);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_ff <= mfs_pkg::mfs_cfg_s'(7'h00);
			chan_cfg_ff <= mfs_pkg::RST_CHANNEL_CONFIG;
			rdata_ff <= 16'h0000;
		end
		else
		begin
			if (wr_sc)
			begin
				cfg_ff.fs_invert <= io_wdata[mfs_pkg::SC_FS_INVERT_BIT];
				cfg_ff.fs_source <= io_wdata[mfs_pkg::SC_FS_SOURCE_BIT];
				cfg_ff.clk_invert <= io_wdata[mfs_pkg::SC_CLK_INVERT_BIT];
				cfg_ff.clk_source <= io_wdata[mfs_pkg::SC_CLK_SOURCE_BIT];
				cfg_ff.prescale_en <= io_wdata[mfs_pkg::SC_PRESCALE_EN_BIT];
				cfg_ff.sign_ext <= io_wdata[mfs_pkg::SC_SIGN_EXT_BIT];
				cfg_ff.byte_mode <= io_wdata[mfs_pkg::SC_BYTE_MODE_BIT];
			end
			if (wr_cc)
				chan_cfg_ff <= io_wdata;
			if (io_rd)
				rdata_ff <= nxt_rdata;
		end
	end

	// zero flag: hardware set beats a write-one clear in the same cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			fs_zero_flag_ff <=
				mfs_pkg::RST_STATUS_CONFIG[mfs_pkg::SC_FS_ZERO_BIT];
		else if (fs_zero)
			fs_zero_flag_ff <= 1'b1;
		else if (wr_sc && io_wdata[mfs_pkg::SC_FS_ZERO_BIT])
			fs_zero_flag_ff <= 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_clock_prescaler_ff <= mfs_pkg::RST_SHIFT_CLOCK_DIV;
			frame_sync_prescaler_ff <= mfs_pkg::RST_FRAME_SYNC_DIV;
		end
		else if (wr_pr)
		begin
			shift_clock_prescaler_ff <= io_wdata[mfs_pkg::PR_SHIFT_LSB +: 8];
			frame_sync_prescaler_ff <= io_wdata[mfs_pkg::PR_FRAME_LSB +: 8];
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt_ff <= 8'h00;
			sck_ff <= 1'b0;
		end
		else if (!cfg_ff.prescale_en || div_wrap)
		begin
			div_cnt_ff <= 8'h00;
			sck_ff <= cfg_ff.prescale_en ? !sck_ff : 1'b0;
		end
		else
			div_cnt_ff <= div_cnt_ff + 8'h01;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			fs_cnt_ff <= 9'h000;
		else if (rise)
			fs_cnt_ff <= fs_zero ? fs_reload : fs_cnt_ff - 9'h001;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ext_fs_ff <= 1'b0;
		else if (rise)
			ext_fs_ff <= ext_lvl;
	end

	// channel sequencer: master pulse, then slaves every 18 shift clocks
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq_act_ff <= 1'b0;
			seq_ch_ff <= 2'd0;
			gap_ff <= 5'd0;
			pulse_ff <= 4'h0;
		end
		else if (trigger && rise)
		begin
			seq_act_ff <= 1'b1;
			seq_ch_ff <= 2'd0;
			gap_ff <= 5'd0;
			pulse_ff <= 4'h1;
		end
		else if (gap_done)
		begin
			gap_ff <= 5'd0;
			seq_act_ff <= more_ch;
			seq_ch_ff <= more_ch ? seq_ch_ff + 2'd1 : seq_ch_ff;
			pulse_ff <= more_ch ? pulse_ff_next(seq_ch_ff) : 4'h0;
		end
		else if (rise)
		begin
			if (seq_act_ff)
				gap_ff <= gap_ff + 5'd1;
			pulse_ff <= 4'h0;
		end
	end

	function automatic logic [3:0] pulse_ff_next(input logic [1:0] ch);
		pulse_ff_next = 4'h1 << (3'(ch) + 3'd1);
	endfunction

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state_ff <= mfs_pkg::TX_IDLE;
			shifter_ff <= 16'h0000;
			bit_cnt_ff <= 4'h0;
		end
		else
		begin
			case (tx_state_ff)
				mfs_pkg::TX_IDLE:
				begin
					if (tx_ready)
					begin
						tx_state_ff <= mfs_pkg::TX_SHIFT;
						shifter_ff <= load_word;
						bit_cnt_ff <= load_cnt;
					end
				end
				mfs_pkg::TX_SHIFT:
				begin
					if (tx_ready)
					begin
						// a new sync mid-word restarts with the new word
						shifter_ff <= load_word;
						bit_cnt_ff <= load_cnt;
					end
					else if (rise)
					begin
						shifter_ff <= {shifter_ff[14:0], 1'b0};
						bit_cnt_ff <= bit_cnt_ff - 4'h1;
						if (bit_cnt_ff == 4'h0)
							tx_state_ff <= mfs_pkg::TX_IDLE;
					end
				end
				default:
					tx_state_ff <= mfs_pkg::TX_IDLE;
			endcase
		end
	end

	wire ch_on2 = enhanced && ch_last >= 2'd1;
	wire ch_on3 = enhanced && ch_last >= 2'd2;
	wire ch_on4 = enhanced && ch_last == 2'd3;

	assign io_rdata = rdata_ff;
	assign shift_clock_pin_o = sck_ff ^ cfg_ff.clk_invert;
	assign transmit_frame_sync_o = pulse_ff[0] ^ cfg_ff.fs_invert;
	assign transmit_frame_sync_oe = drive_fs;
	assign receive_clock_pin_o = pulse_ff[1] ^ cfg_ff.fs_invert;
	assign receive_clock_pin_oe = ch_on2 && drive_fs;
	assign receive_frame_sync_o = pulse_ff[2] ^ cfg_ff.fs_invert;
	assign receive_frame_sync_oe = ch_on3 && drive_fs;
	assign general_purpose_pin_o = ch_on4
		? pulse_ff[3] ^ cfg_ff.fs_invert : gp_out_value;
	assign general_purpose_pin_oe = ch_on4 ? drive_fs : gp_drive;
	assign gp_in_value = general_purpose_pin_i;
	assign serial_data_out_o = !tx_idle && shifter_ff[15];
	assign serial_data_out_oe = !tx_idle;
	assign transmit_busy = !tx_idle;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_pulse_out;
		rise && pulse_ff != 4'h0;
	endsequence

	a_fs_pin_dir: assert property
		(transmit_frame_sync_oe == transmit_mode_bit)
		else $error("frame sync direction does not follow mode bit");
	a_start_loads: assert property
		(tx_ready |=> !tx_idle && bit_cnt_ff == load_cnt_q)
		else $error("frame sync fall did not start a word");
	a_data_hiz: assert property
		(tx_idle |-> !serial_data_out_oe && !serial_data_out_o)
		else $error("data pin driven while idle");
	a_pulse_one_period: assert property
		(s_pulse_out |=> pulse_ff == 4'h0)
		else $error("frame sync longer than one shift period");
	a_gap_bound: assert property
		(gap_ff <= mfs_pkg::FS_SPACING_LAST)
		else $error("channel spacing counter overran");
	a_slave_order: assert property
		(gap_done && more_ch |=> pulse_ff != 4'h0 && seq_ch_ff != 2'd0)
		else $error("slave pulse missing after spacing");
	a_basic_single: assert property
		(!enhanced |-> pulse_ff[3:1] == 3'b000)
		else $error("slave sync in basic mode");
	a_gp_basic: assert property
		(!enhanced |-> general_purpose_pin_oe == gp_drive)
		else $error("gp pin taken in basic mode");
	a_fs_reload: assert property
		(fs_zero |=> fs_cnt_ff == $past(fs_reload))
		else $error("frame prescaler reload wrong");
	a_flag_set: assert property
		(fs_zero |=> fs_zero_flag_ff)
		else $error("prescaler zero flag not set");

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			load_cnt_q <= 4'h0;
		else
			load_cnt_q <= load_cnt;
	end
endmodule

// ### tb/mfs_codec_model.sv
// far-side model: up to four codecs sharing data and shift clock lines
// assumes sync lines are resolved pin levels, sampled mid shift period
`timescale 1ns/1ps
module mfs_codec_model
(
	input  wire logic       sck,
	input  wire logic [3:0] sync,
	input  wire logic       sd,
	input  wire logic       sd_oe,
	output logic            sd_in
);
	int          rises = 0;
	int          bits = 0;
	int          period = 0;
	int          first[4] = '{default: 0};
	int          gap[4] = '{default: 0};
	int          width[4] = '{default: 0};
	int          cnt[4] = '{default: 0};
	logic [3:0]  prev = 4'h0;
	logic [15:0] word = 16'h0000;

	// released data-in line idles high through its pull-up
	assign sd_in = 1'b1;

	always @(posedge sck)
		rises <= rises + 1;

	// sampling at the falling edge keeps clear of launch-edge races
	always @(negedge sck)
	begin
		for (int c = 0; c < 4; c++)
		begin
			if (sync[c] === 1'b1 && prev[c] !== 1'b1)
			begin
				if (c == 0 && cnt[0] > 0)
					period = rises - first[0];
				if (c > 0)
					gap[c] = rises - first[c - 1];
				first[c] = rises;
				cnt[c]++;
				width[c] = 0;
			end
			if (sync[c] === 1'b1)
				width[c]++;
		end
		// only channel one owns the data word; others share the line
		if (sync[0] !== 1'b1 && prev[0] === 1'b1 && sd_oe)
			bits = 16;
		if (bits > 0)
		begin
			word = {word[14:0], sd};
			bits--;
		end
		prev = sync;
	end
endmodule

// ### tb/mfs_frame_sync_bench.sv
// self-checking bench for the frame-sync block with a codec far side
// assumes single 250 MHz clock and register strobes per the hand-over
`timescale 1ns/1ps
module mfs_frame_sync_bench;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] io_addr = 16'h0000;
	logic [15:0] io_wdata = 16'h0000;
	logic        io_wr = 1'b0;
	logic        io_rd = 1'b0;
	logic [15:0] io_rdata;
	logic        mode = 1'b0;
	logic [15:0] tx_word = 16'h0000;
	logic        tx_valid = 1'b0;
	logic        tx_ready;
	logic        sdi;
	logic        sck;
	logic        fs_o, fs_oe, rck_o, rck_oe, rfs_o, rfs_oe;
	logic        gp_o, gp_oe, gp_val = 1'b0, gp_drv = 1'b0, gp_in;
	logic        sd_o, sd_oe, busy;
	logic        ext_fs = 1'b0;
	wire         transmit_frame_sync = fs_oe ? fs_o : ext_fs;
	wire         rck = rck_oe ? rck_o : 1'b0;
	wire         rfs = rfs_oe ? rfs_o : 1'b0;
	wire         gp = gp_oe ? gp_o : 1'b1;
	wire         sd = sd_oe ? sd_o : 1'bz;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          n;

	mfs_frame_sync dut (.clock(clock), .rst_n(rst_n), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
		.io_rdata(io_rdata), .transmit_mode_bit(mode), .tx_word(tx_word),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .serial_data_in(sdi),
		.shift_clock_pin_o(sck), .transmit_frame_sync_i(transmit_frame_sync),
		.transmit_frame_sync_o(fs_o), .transmit_frame_sync_oe(fs_oe),
		.receive_clock_pin_o(rck_o), .receive_clock_pin_oe(rck_oe),
		.receive_frame_sync_o(rfs_o), .receive_frame_sync_oe(rfs_oe),
		.general_purpose_pin_i(gp), .general_purpose_pin_o(gp_o),
		.general_purpose_pin_oe(gp_oe), .gp_out_value(gp_val),
		.gp_drive(gp_drv), .gp_in_value(gp_in), .serial_data_out_o(sd_o),
		.serial_data_out_oe(sd_oe), .transmit_busy(busy));

	mfs_codec_model codec (.sck(sck), .sync({gp, rfs, rck, transmit_frame_sync}), .sd(sd),
		.sd_oe(sd_oe), .sd_in(sdi));

	initial
	begin
		forever #2 clock = ~clock;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard: whole run needs well under this many cycles
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	// word consumed: withdraw the offer
	always @(posedge clock)
		if (tx_ready === 1'b1)
			tx_valid <= 1'b0;

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic chk_cnt(input int got, input int exp);
		checks_done++;
		if (got != exp)
		begin
			mismatches++;
			$display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clock);
		io_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clock);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clock);
		io_rd <= 1'b0;
		@(posedge clock);
		chk_val(io_rdata, exp);
	endtask

	initial
	begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		chk_bit(fs_oe, 1'b0);
		chk_bit(sd_oe, 1'b0);
		rd(mfs_pkg::ADDR_STATUS_CONFIG, 16'h8000);
		rd(mfs_pkg::ADDR_CHANNEL_CONFIG, 16'h0000);
		rd(mfs_pkg::ADDR_PRESCALER, 16'h0000);
		rd(16'h0010, 16'h0000);
		gp_drv <= 1'b1;
		gp_val <= 1'b1;
		repeat (2) @(posedge clock);
		chk_bit(gp, 1'b1);
		chk_bit(gp_oe, 1'b1);
		gp_val <= 1'b0;
		repeat (2) @(posedge clock);
		chk_bit(gp, 1'b0);
		chk_bit(gp_in, 1'b0);
		chk_bit(rck_oe, 1'b0);
		wr(mfs_pkg::ADDR_PRESCALER, 16'h2800);
		rd(mfs_pkg::ADDR_PRESCALER, 16'h2800);
		wr(mfs_pkg::ADDR_CHANNEL_CONFIG, 16'h0007);
		rd(mfs_pkg::ADDR_CHANNEL_CONFIG, 16'h0007);
		mode <= 1'b1;
		tx_word <= 16'ha5c3;
		tx_valid <= 1'b1;
		repeat (2) @(posedge clock);
		chk_bit(fs_oe, 1'b1);
		chk_bit(rck_oe, 1'b1);
		chk_bit(rfs_oe, 1'b1);
		chk_bit(gp_oe, 1'b1);
		wr(mfs_pkg::ADDR_STATUS_CONFIG, 16'h2100);
		repeat (600) @(posedge clock);
		chk_val(codec.word, 16'ha5c3);
		for (n = 1; n < 4; n++)
			chk_cnt(codec.gap[n], 18);
		for (n = 0; n < 4; n++)
			chk_cnt(codec.width[n], 1);
		chk_cnt(codec.period, 2 * (40 + 1));
		rd(mfs_pkg::ADDR_STATUS_CONFIG, 16'hb100);
		wr(mfs_pkg::ADDR_STATUS_CONFIG, 16'h0000);
		wr(mfs_pkg::ADDR_CHANNEL_CONFIG, 16'h0005);
		repeat (2) @(posedge clock);
		chk_bit(rck_oe, 1'b1);
		chk_bit(rfs_oe, 1'b0);
		chk_bit(gp, 1'b0);
		wr(mfs_pkg::ADDR_CHANNEL_CONFIG, 16'h0000);
		tx_word <= 16'h5a3c;
		tx_valid <= 1'b1;
		wr(mfs_pkg::ADDR_STATUS_CONFIG, 16'h0100);
		repeat (200) @(posedge clock);
		chk_val(codec.word, 16'h5a3c);
		n = codec.cnt[0];
		repeat (200) @(posedge clock);
		chk_cnt(codec.cnt[0], n);
		chk_bit(sd_oe, 1'b0);
		mode <= 1'b0;
		tx_word <= 16'h3c5a;
		tx_valid <= 1'b1;
		repeat (2) @(posedge clock);
		chk_bit(fs_oe, 1'b0);
		ext_fs <= 1'b1;
		repeat (8) @(posedge clock);
		ext_fs <= 1'b0;
		n = 0;
		while (busy !== 1'b1 && n < 100)
		begin
			@(posedge clock);
			n++;
		end
		chk_bit(busy, 1'b1);
		end_of_test();
	end
endmodule
